// file: logic/move_or_instruction_exec.sv
`timescale 1ns/100ps
`include "move_or_cfg.svh"
module move_or_instruction_exec (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic [`INSN_W-1:0]  insn,
    input  wire logic                insn_valid,
    output logic                     insn_ready,
    output logic                     done,
    output logic                     illegal,
    output logic      [`DATA_W-1:0]  work,
    output logic                     zero_flag,
    output logic      [`DATA_W-1:0]  file_rd_data
);
    move_or_pkg::phase_t   phase_r;
    move_or_pkg::phase_t   phase_nxt;
    move_or_pkg::decoded_t dec_r;
    move_or_pkg::decoded_t dec_nxt;
    logic [`DATA_W-1:0]    work_r;
    logic [`DATA_W-1:0]    work_nxt;
    logic                  zero_r;
    logic                  zero_nxt;
    logic [`DATA_W-1:0]    result_r;
    logic [`DATA_W-1:0]    result_nxt;
    logic                  done_r;
    logic                  done_nxt;
    logic                  illegal_r;
    logic                  illegal_nxt;
    logic                  busy_r;
    logic                  busy_nxt;
    logic [`DATA_W-1:0]    fr_data;
    logic                  fr_wr_en;
    logic [`DATA_W-1:0]    fr_wr_data;
    logic                  take;
    logic                  in_process;
    logic                  in_write;

    function automatic move_or_pkg::decoded_t decode(input logic [`INSN_W-1:0] w);
        move_or_pkg::decoded_t d;
        d.kind      = move_or_pkg::OPK_NONE;
        d.dest_file = w[`DEST_BIT];
        d.faddr     = w[`FADDR_W-1:0];
        d.literal   = w[`DATA_W-1:0];
        if (w[13:12] == `OP_LIT_PAIR && w[11:10] == 2'h0) begin
            d.kind = move_or_pkg::OPK_LIT;
        end else if (w[13:12] == `OP_LIT_PAIR && w[11:10] != 2'h0) begin
            d.kind = move_or_pkg::OPK_LIT;
        end else if (w[13:8] == `OP_OR_WORK) begin
            d.kind = move_or_pkg::OPK_OR;
        end else if (w[13:8] == `OP_MOVE_FILE) begin
            d.kind = move_or_pkg::OPK_MOVE;
        end else if (w[13:8] == `OP_STORE_WORK && w[`DEST_BIT]) begin
            d.kind = move_or_pkg::OPK_STORE;
        end
        return d;
    endfunction : decode

    file_regs u_file_regs (
        .clk     (clk),
        .rstn    (rstn),
        .rd_addr (dec_r.faddr),
        .rd_data (fr_data),
        .wr_en   (fr_wr_en),
        .wr_addr (dec_r.faddr),
        .wr_data (fr_wr_data)
    );

    // only accept a word at the start of a cycle
    assign insn_ready = !busy_r;
    // take only in the decode phase; ready mirrors this through busy
    assign take       = (phase_r == move_or_pkg::PH_DECODE) && insn_valid;
    assign in_process = (phase_r == move_or_pkg::PH_PROCESS);
    assign in_write   = (phase_r == move_or_pkg::PH_WRITE);

    always_comb begin
        phase_nxt = phase_r;
        busy_nxt  = busy_r;
        case (phase_r)
            move_or_pkg::PH_DECODE: begin
                if (insn_valid) begin
                    busy_nxt  = 1'b1;
                    phase_nxt = move_or_pkg::PH_READ;
                end
            end
            move_or_pkg::PH_READ: begin
                // memory read data lands after this edge
                phase_nxt = move_or_pkg::PH_PROCESS;
            end
            move_or_pkg::PH_PROCESS: begin
                phase_nxt = move_or_pkg::PH_WRITE;
            end
            move_or_pkg::PH_WRITE: begin
                // ready returns with done, so words can run back to back
                busy_nxt  = 1'b0;
                phase_nxt = move_or_pkg::PH_DECODE;
            end
            default: begin
                // unused phase codes fall back to decode
                busy_nxt  = 1'b0;
                phase_nxt = move_or_pkg::PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= move_or_pkg::PH_DECODE;
            busy_r  <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // word is latched once, so the source may change insn after the take
    always_comb begin
        dec_nxt = dec_r;
        if (take) begin
            dec_nxt = decode(insn);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dec_r <= '0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    // result staged a cycle so the write phase sees a settled value
    always_comb begin
        result_nxt = result_r;
        work_nxt   = work_r;
        zero_nxt   = zero_r;
        fr_wr_en   = 1'b0;
        fr_wr_data = result_r;
        if (in_process) begin
            case (dec_r.kind)
                move_or_pkg::OPK_OR:    result_nxt = work_r | fr_data;
                move_or_pkg::OPK_LIT:   result_nxt = dec_r.literal;
                move_or_pkg::OPK_MOVE:  result_nxt = fr_data;
                move_or_pkg::OPK_STORE: result_nxt = work_r;
                default:                result_nxt = result_r;
            endcase
        end
        if (in_write) begin
            case (dec_r.kind)
                move_or_pkg::OPK_OR, move_or_pkg::OPK_MOVE: begin
                    if (dec_r.dest_file) begin
                        fr_wr_en = 1'b1;
                    end else begin
                        work_nxt = result_r;
                    end
                    zero_nxt = (result_r == '0);
                end
                move_or_pkg::OPK_LIT: begin
                    work_nxt = result_r;
                end
                move_or_pkg::OPK_STORE: begin
                    fr_wr_en = 1'b1;
                end
                default: begin
                    // unknown word: nothing written, flags kept
                    fr_wr_en = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            work_r   <= `WORK_RST;
            zero_r   <= `ZERO_RST;
            result_r <= '0;
        end else begin
            work_r   <= work_nxt;
            zero_r   <= zero_nxt;
            result_r <= result_nxt;
        end
    end

    // status pulses stand exactly the cycle after the write phase
    always_comb begin
        done_nxt    = in_write;
        illegal_nxt = in_write && (dec_r.kind == move_or_pkg::OPK_NONE);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_r    <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            done_r    <= done_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign work         = work_r;
    assign zero_flag    = zero_r;
    assign done         = done_r;
    assign illegal      = illegal_r;
    assign file_rd_data = fr_data;
endmodule : move_or_instruction_exec

// file: logic/move_or_cfg.svh
`ifndef MOVE_OR_CFG_SVH
`define MOVE_OR_CFG_SVH
// instruction word layout
`define INSN_W          14
`define FADDR_W         7
`define DATA_W          8
`define DEST_BIT        7
// opcode patterns, upper six bits
`define OP_OR_WORK      6'h04
`define OP_MOVE_FILE    6'h08
`define OP_STORE_WORK   6'h00
// literal load: top pair 2'b11, next two bits ignored
`define OP_LIT_PAIR     2'h3
`define WORK_RST        8'h00
`define ZERO_RST        1'h0
`define FILE_DEPTH      128
`endif

// file: logic/move_or_pkg.sv
package move_or_pkg;
    typedef enum logic [2:0] {
        OPK_NONE,
        OPK_OR,
        OPK_LIT,
        OPK_MOVE,
        OPK_STORE
    } op_kind_t;

    typedef struct packed {
        op_kind_t   kind;
        logic       dest_file;
        logic [6:0] faddr;
        logic [7:0] literal;
    } decoded_t;

    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } phase_t;
endpackage : move_or_pkg

// file: logic/file_regs.sv
`timescale 1ns/100ps
`include "move_or_cfg.svh"
module file_regs (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [`FADDR_W-1:0]   rd_addr,
    output logic      [`DATA_W-1:0]    rd_data,
    input  wire logic                  wr_en,
    input  wire logic [`FADDR_W-1:0]   wr_addr,
    input  wire logic [`DATA_W-1:0]    wr_data
);
    logic [`DATA_W-1:0] mem [0:`FILE_DEPTH-1];
    logic [`DATA_W-1:0] rd_data_nxt;

    always_comb begin
        rd_data_nxt = mem[rd_addr];
    end

    // storage has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_data_nxt;
        end
    end
endmodule : file_regs

// file: verif/move_or_checker.sv
`timescale 1ns/100ps
`include "move_or_cfg.svh"
module move_or_checker (
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic [`INSN_W-1:0] insn,
    input wire logic               insn_valid,
    input wire logic               insn_ready,
    input wire logic               done,
    input wire logic               illegal,
    input wire logic [`DATA_W-1:0] work,
    input wire logic               zero_flag,
    input wire logic [`DATA_W-1:0] file_rd_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire       tk  = insn_valid && insn_ready;
    wire [7:0] lit = insn[7:0];
    wire       zop = insn[13:8] == 6'h04 || insn[13:8] == 6'h08;
    a_done_lat: assert property (tk |=> !done [*3] ##1 done)
        else $error("done latency wrong");
    a_busy_refuse: assert property (tk |=> !insn_ready [*3] ##1 insn_ready)
        else $error("ready window wrong");
    a_lit_load: assert property (tk && insn[13:12] == 2'h3
        |-> ##4 work == $past(lit, 4) && $stable(zero_flag)) else $error("literal load wrong");
    a_lit_any: assert property (tk && insn[13:12] == 2'h3 |-> ##4 done && !illegal)
        else $error("literal refused");
    a_store_keep: assert property (tk && insn[13:7] == 7'h01
        |-> ##4 $stable(work) && $stable(zero_flag) && !illegal) else $error("store touched work");
    a_store_data: assert property (tk && insn[13:7] == 7'h01
        |-> ##5 file_rd_data == $past(work, 5)) else $error("stored value not in file");
    a_zero_track: assert property (tk && zop && !insn[7]
        |-> ##4 zero_flag == (work == 8'h00)) else $error("zero flag wrong");
    a_file_dest: assert property (tk && zop && insn[7] |-> ##4 $stable(work))
        else $error("file dest wrote work");
    a_bad_word: assert property (tk && insn[13:7] == 7'h00 |-> ##4 illegal)
        else $error("bad word not flagged");
    a_ill_done: assert property (illegal |-> done)
        else $error("illegal without done");
endmodule : move_or_checker
bind move_or_instruction_exec move_or_checker chk (.clk(clk), .rstn(rstn), .insn(insn), .insn_valid(insn_valid),
    .insn_ready(insn_ready), .done(done), .illegal(illegal), .work(work), .zero_flag(zero_flag),
    .file_rd_data(file_rd_data));

// file: verif/insn_source.sv
`timescale 1ns/100ps
`include "move_or_cfg.svh"
module insn_source (
    input  wire logic               clk,
    output logic      [`INSN_W-1:0] insn,
    output logic                    insn_valid,
    input  wire logic               insn_ready,
    output logic                    hung
);
    int n;
    initial begin
        insn = 14'h0000;
        insn_valid = 1'h0;
        hung = 1'h0;
    end
    task automatic send(input logic [`INSN_W-1:0] w, input int gap);
        // at least one edge passes, so valid is never assigned twice in one step
        repeat (gap + 1) @(posedge clk);
        #1 insn = w;
        insn_valid = 1'h1;
        n = 0;
        while (insn_ready !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        hung = hung | (n == 20);
        // scrambled after release so nothing leans on a stale word
        #1 insn = ~w;
        insn_valid = 1'h0;
    endtask : send
endmodule : insn_source

// file: verif/tb_top.sv
`timescale 1ns/100ps
`include "move_or_cfg.svh"
module tb_top;
    logic               clk, rstn, valid, ready, done, ill, zf, hung, zm;
    logic [`INSN_W-1:0] insn;
    logic [7:0]         work, fdat, wm;
    logic [7:0]         fm [128];
    logic [9:0]         q [$];
    logic [9:0]         e;
    logic [5:0]         ops [4] = '{6'h04, 6'h08, 6'h00, 6'h30};
    int                 seed = 13, err_total = 0, checked = 0, i, k;
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    move_or_instruction_exec uut (.clk(clk), .rstn(rstn), .insn(insn), .insn_valid(valid), .insn_ready(ready),
        .done(done), .illegal(ill), .work(work), .zero_flag(zf), .file_rd_data(fdat));
    insn_source src (.clk(clk), .insn(insn), .insn_valid(valid), .insn_ready(ready), .hung(hung));
    task run(input logic [13:0] w);
        logic [7:0] f;
        logic [7:0] r;
        logic       x;
        f = fm[w[6:0]];
        x = 1'h0;
        if (w[13:12] == 2'h3) wm = w[7:0];
        else if (w[13:8] == 6'h04) begin
            r = wm | f;
            zm = r == 8'h00;
            if (w[7]) fm[w[6:0]] = r;
            else wm = r;
        end else if (w[13:8] == 6'h08) begin
            zm = f == 8'h00;
            if (!w[7]) wm = f;
        end else if (w[13:7] == 7'h01) fm[w[6:0]] = wm;
        else x = 1'h1;
        q.push_back({x, zm, wm});
        src.send(w, $random(seed) & 3);
    endtask : run
    task wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    always @(negedge clk) begin
        if (done === 1'h1) begin
            e = (q.size() > 0) ? q.pop_front() : 10'h3ff;
            checked++;
            if ({ill, zf, work} !== e) begin
                $display("[FAIL] result exp %h got %h", e, {ill, zf, work});
                err_total++;
            end
        end
    end
    initial begin
        rstn = 1'h0;
        wm = 8'h00;
        zm = 1'h0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'h1;
        for (i = 0; i < 10; i++) begin
            run({6'h30, 8'($random(seed))});
            run({7'h01, 7'((i == 9) ? 127 : i)});
        end
        $display("test preload done");
        for (i = 0; i < 4; i++) run({2'h3, 2'(i), 2'(3 - i), 8'($random(seed))});
        $display("test literal done");
        run({6'h30, 8'h00});
        run({7'h01, 7'h03});
        run({6'h04, 1'h0, 7'h03});
        run({6'h08, 1'h1, 7'h03});
        run({6'h04, 1'h1, 7'h05});
        run({6'h08, 1'h0, 7'h05});
        run(14'h0005);
        $display("test directed done");
        for (i = 0; i < 40; i++) begin
            k = $random(seed);
            run({ops[k & 3], 1'(k >> 4), 7'(k[12] ? 127 : k[10:8])});
        end
        $display("test random done");
        for (i = 0; i < 100 && q.size() > 0; i++) @(posedge clk);
        if (q.size() > 0 || hung) err_total++;
        wrap_up();
    end
endmodule : tb_top
